// file: rtl/bio_cfg_store.sv
/*
 * Writable bits of the onboard configuration register.
 * Assumes a one-cycle write enable already decoded to this register.
 */
`timescale 1ns/1ps
module bio_cfg_store (
	input  wire logic               clk_sys,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire logic               wr_en,
	input  wire logic [7:0]         wr_data,
	output bio_pkg::bio_cfg_out_t   cfg
);

	typedef struct packed {
		bio_pkg::bio_cfg_out_t cfg;
	} bio_cfg_state_t;

	bio_cfg_state_t state_reg;
	bio_cfg_state_t state_next;

	// only the writable positions are taken; the rest drop silently
	always_comb begin
		state_next = state_reg;
		if (wr_en) begin
			state_next.cfg.boot_progress_led_disable =
				wr_data[bio_pkg::CFG_BOOT_PROGRESS_LED_DISABLE_DIS_POS];
			state_next.cfg.hub_select =
				wr_data[bio_pkg::CFG_HUB_SEL_POS];
			state_next.cfg.general_led_mode =
				wr_data[bio_pkg::CFG_LED_MODE_POS];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign cfg = state_reg.cfg;

endmodule : bio_cfg_store

// file: rtl/bio_irq_ctrl.sv
/*
 * Sticky event flags, mask and level interrupt for the register bank.
 * Assumes event levels arrive registered and a read-clear strobe
 * that is one cycle long.
 */
`timescale 1ns/1ps
module bio_irq_ctrl #(
	parameter int N = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         ce,
	input  wire logic [N-1:0] evt_lvl,
	input  wire logic         sts_rd_clr,
	input  wire logic         mask_wr,
	input  wire logic [N-1:0] mask_data,
	output logic [N-1:0]      sts,
	output logic [N-1:0]      mask,
	output logic              irq
);

	typedef struct packed {
		logic [N-1:0] prev;
		logic [N-1:0] sts;
		logic [N-1:0] mask;
		logic         irq;
	} bio_irq_state_t;

	bio_irq_state_t state_reg;
	bio_irq_state_t state_next;
	logic [N-1:0]   rise;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_edge
			assign rise[g] = evt_lvl[g] & ~state_reg.prev[g];
		end
	endgenerate

	// a new event in the clearing cycle survives the clear
	always_comb begin
		state_next      = state_reg;
		state_next.prev = evt_lvl;
		state_next.sts  = (sts_rd_clr ? '0 : state_reg.sts) | rise;
		if (mask_wr) begin
			state_next.mask = mask_data;
		end
		state_next.irq = |(state_next.sts & state_next.mask);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign sts  = state_reg.sts;
	assign mask = state_reg.mask;
	assign irq  = state_reg.irq;

endmodule : bio_irq_ctrl

// file: rtl/bio_pkg.sv
/*
 * Package for the board I/O status and configuration register bank:
 * register offsets, field positions, reset values and carrier structs.
 * Assumes an 8-bit register port with a 12-bit I/O address.
 */
package bio_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int EVT_N  = 3;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_IO_STATUS  = 12'h286;
	localparam logic [11:0] OFF_ONBOARD_CFG = 12'h287;
	localparam logic [11:0] OFF_BOARD_IDENTITY   = 12'h288;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h290;
	localparam logic [11:0] OFF_IRQ_MASK   = 12'h291;

	// ------------------------------------------------------------
	// input/output status fields
	// ------------------------------------------------------------
	localparam int STS_DERATE_POS = 0;
	localparam int STS_FAIL_POS   = 1;
	localparam int STS_ENUM_POS   = 2;
	localparam int STS_SLOT_POS   = 3;
	localparam int STS_HUB_LSB    = 4;
	localparam int STS_HUB_MSB    = 5;
	localparam logic [1:0] HUB_CODE_FIRST  = 2'h0;
	localparam logic [1:0] HUB_CODE_SECOND = 2'h1;

	// ------------------------------------------------------------
	// onboard configuration fields
	// ------------------------------------------------------------
	localparam int CFG_LED_MODE_POS   = 0;
	localparam int CFG_LOC_PROTO_POS  = 1;
	localparam int CFG_LOC_SPEED_POS  = 2;
	localparam int CFG_BP_PROTO_POS   = 3;
	localparam int CFG_BP_SPEED_POS   = 4;
	localparam int CFG_HUB_SEL_POS    = 5;
	localparam int CFG_BOOT_PROGRESS_LED_DISABLE_DIS_POS   = 6;
	localparam logic [7:0] CFG_WR_MASK = 8'h61;

	// ------------------------------------------------------------
	// interrupt event bits
	// ------------------------------------------------------------
	localparam int EVT_DERATE_POS = 0;
	localparam int EVT_FAIL_POS   = 1;
	localparam int EVT_ENUM_POS   = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_IO_STATUS = 8'h00;
	localparam logic [7:0] RST_CFG       = 8'h00;
	localparam logic [7:0] RST_RD_DATA   = 8'h00;
	localparam logic [2:0] RST_IRQ_BITS  = 3'h0;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] booted_hub_code;
		logic       slot_type_flag;
		logic       hot_insert_event_flag;
		logic       supply_failure_flag;
		logic       supply_derating_flag;
	} bio_status_in_t;

	typedef struct packed {
		logic backplane_speed_flag;
		logic backplane_protocol_flag;
		logic local_speed_flag;
		logic local_protocol_flag;
	} bio_strap_in_t;

	typedef struct packed {
		logic boot_progress_led_disable;
		logic hub_select;
		logic general_led_mode;
	} bio_cfg_out_t;

	function automatic logic bio_hit(input logic [11:0] addr,
		input logic [11:0] off);
		return addr == off;
	endfunction : bio_hit

endpackage : bio_pkg

// file: rtl/bio_regs.sv
/*
 * Board I/O register bank: input/output status, onboard configuration,
 * board identity, plus event status and mask behind one interrupt.
 * Assumes board lines and straps are synchronous to clk_sys and a
 * plain register port whose read data appears one cycle after the
 * read strobe.
 */
`timescale 1ns/1ps

// Summary of operation
// - two-bit code reports which hub booted
// - bit 3 tells system from peripheral slot
// - bit 1 shows power supply fail line
// - config bit 4 shows backplane speed strap
// - eight-bit read-only board identity register
// - identity is fixed per board type
module bio_regs #(
	// arbitrary neutral identity value, not tied to any board
	parameter logic [7:0] BOARD_IDENTITY_CODE = 8'h5C
) (
	input  wire logic                    clk_sys,
	input  wire logic                    srst,
	input  wire logic                    ce,
	input  wire logic [11:0]             addr,
	input  wire logic [7:0]              wr_data,
	input  wire logic                    wr_stb,
	input  wire logic                    rd_stb,
	output logic [7:0]                   rd_data,
	input  wire bio_pkg::bio_status_in_t status_in,
	input  wire bio_pkg::bio_strap_in_t  strap_in,
	output bio_pkg::bio_cfg_out_t        cfg_out,
	output logic                         irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]             io_status;
		bio_pkg::bio_strap_in_t strap;
		logic [7:0]             rd_data;
	} bio_regs_state_t;

	bio_regs_state_t state_reg;
	bio_regs_state_t state_next;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic hit_status;
	logic hit_cfg;
	logic hit_id;
	logic hit_irq_sts;
	logic hit_irq_mask;
	logic cfg_wr;
	logic mask_wr;
	logic irq_sts_rd;

	assign hit_status   = bio_pkg::bio_hit(addr, bio_pkg::OFF_IO_STATUS);
	assign hit_cfg      = bio_pkg::bio_hit(addr,
		bio_pkg::OFF_ONBOARD_CFG);
	assign hit_id       = bio_pkg::bio_hit(addr, bio_pkg::OFF_BOARD_IDENTITY);
	assign hit_irq_sts  = bio_pkg::bio_hit(addr, bio_pkg::OFF_IRQ_STATUS);
	assign hit_irq_mask = bio_pkg::bio_hit(addr, bio_pkg::OFF_IRQ_MASK);

	// writes to read-only and unmapped offsets have no effect
	assign cfg_wr     = wr_stb & hit_cfg;
	assign mask_wr    = wr_stb & hit_irq_mask;
	assign irq_sts_rd = rd_stb & hit_irq_sts;

	// ------------------------------------------------------------
	// configuration storage
	// ------------------------------------------------------------
	bio_pkg::bio_cfg_out_t cfg_q;

	bio_cfg_store u_cfg (
		.clk_sys (clk_sys),
		.srst    (srst),
		.ce      (ce),
		.wr_en   (cfg_wr),
		.wr_data (wr_data),
		.cfg     (cfg_q)
	);

	// ------------------------------------------------------------
	// event flags and interrupt
	// ------------------------------------------------------------
	logic [bio_pkg::EVT_N-1:0] evt_lvl;
	logic [bio_pkg::EVT_N-1:0] irq_sts;
	logic [bio_pkg::EVT_N-1:0] irq_mask;

	// events follow the registered snapshot so they match what reads see
	assign evt_lvl[bio_pkg::EVT_DERATE_POS] =
		state_reg.io_status[bio_pkg::STS_DERATE_POS];
	assign evt_lvl[bio_pkg::EVT_FAIL_POS] =
		state_reg.io_status[bio_pkg::STS_FAIL_POS];
	assign evt_lvl[bio_pkg::EVT_ENUM_POS] =
		state_reg.io_status[bio_pkg::STS_ENUM_POS];

	bio_irq_ctrl #(
		.N (bio_pkg::EVT_N)
	) u_irq (
		.clk_sys    (clk_sys),
		.srst       (srst),
		.ce         (ce),
		.evt_lvl    (evt_lvl),
		.sts_rd_clr (irq_sts_rd),
		.mask_wr    (mask_wr),
		.mask_data  (wr_data[bio_pkg::EVT_N-1:0]),
		.sts        (irq_sts),
		.mask       (irq_mask),
		.irq        (irq)
	);

	// ------------------------------------------------------------
	// status snapshot
	// ------------------------------------------------------------
	logic [7:0] status_word;

	always_comb begin
		status_word = bio_pkg::RST_IO_STATUS;
		status_word[bio_pkg::STS_HUB_MSB:bio_pkg::STS_HUB_LSB] =
			status_in.booted_hub_code;
		status_word[bio_pkg::STS_SLOT_POS] =
			status_in.slot_type_flag;
		status_word[bio_pkg::STS_ENUM_POS] =
			status_in.hot_insert_event_flag;
		status_word[bio_pkg::STS_FAIL_POS] =
			status_in.supply_failure_flag;
		status_word[bio_pkg::STS_DERATE_POS] =
			status_in.supply_derating_flag;
	end

	// ------------------------------------------------------------
	// configuration read view
	// ------------------------------------------------------------
	logic [7:0] cfg_word;

	always_comb begin
		cfg_word = bio_pkg::RST_CFG;
		cfg_word[bio_pkg::CFG_BOOT_PROGRESS_LED_DISABLE_DIS_POS] =
			cfg_q.boot_progress_led_disable;
		cfg_word[bio_pkg::CFG_HUB_SEL_POS] = cfg_q.hub_select;
		cfg_word[bio_pkg::CFG_BP_SPEED_POS] =
			state_reg.strap.backplane_speed_flag;
		cfg_word[bio_pkg::CFG_BP_PROTO_POS] =
			state_reg.strap.backplane_protocol_flag;
		cfg_word[bio_pkg::CFG_LOC_SPEED_POS] =
			state_reg.strap.local_speed_flag;
		cfg_word[bio_pkg::CFG_LOC_PROTO_POS] =
			state_reg.strap.local_protocol_flag;
		cfg_word[bio_pkg::CFG_LED_MODE_POS] = cfg_q.general_led_mode;
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [7:0] rd_mux;

	// unused high bits of the narrow event registers read as zero
	always_comb begin
		rd_mux = bio_pkg::RD_UNMAPPED;
		if (hit_status) begin
			rd_mux = state_reg.io_status;
		end else if (hit_cfg) begin
			rd_mux = cfg_word;
		end else if (hit_id) begin
			rd_mux = BOARD_IDENTITY_CODE;
		end else if (hit_irq_sts) begin
			rd_mux[bio_pkg::EVT_N-1:0] = irq_sts;
		end else if (hit_irq_mask) begin
			rd_mux[bio_pkg::EVT_N-1:0] = irq_mask;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// read data stands one cycle for each cycle of read strobe, then returns to zero
	always_comb begin
		state_next           = state_reg;
		state_next.io_status = status_word;
		state_next.strap     = strap_in;
		state_next.rd_data   = rd_stb ? rd_mux : bio_pkg::RST_RD_DATA;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg.io_status <= bio_pkg::RST_IO_STATUS;
			state_reg.strap     <= '0;
			state_reg.rd_data   <= bio_pkg::RST_RD_DATA;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rd_data = state_reg.rd_data;
	assign cfg_out = cfg_q;

endmodule : bio_regs

// file: testbench/bio_regs_bench.sv
/* self-checking bench for bio_regs, random and corner stimulus.
   no partner: the bench drives every port itself. */
`timescale 1ns/1ps
module bio_regs_bench;
	// arbitrary identity value
	localparam logic [7:0] ID = 8'h3B;
	logic                    clk_sys, srst, ce, wr_stb, rd_stb, irq;
	logic [11:0]             addr;
	logic [7:0]              wr_data, rd_data, d, w;
	bio_pkg::bio_status_in_t status_in;
	bio_pkg::bio_strap_in_t  strap_in;
	bio_pkg::bio_cfg_out_t   cfg_out;
	int                      err_total, checks_done, n;

	bio_regs #(.BOARD_IDENTITY_CODE(ID)) dut (.clk_sys(clk_sys), .srst(srst),
		.ce(ce), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rd_data(rd_data), .status_in(status_in),
		.strap_in(strap_in), .cfg_out(cfg_out), .irq(irq));

	initial clk_sys = 1'b0;
	always #25 clk_sys = ~clk_sys;

	// --------------------------------
	// helpers
	// --------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		@(negedge clk_sys);
		v = rd_data;
	endtask : rd

	function automatic logic [7:0] cfg_exp(input logic [7:0] v,
		input logic [3:0] s);
		return (v & 8'h61) | {3'h0, s, 1'h0};
	endfunction : cfg_exp

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// waits for irq a bounded time
	task automatic wait_irq();
		for (n = 0; n < 6 && irq !== 1'b1; n++) @(negedge clk_sys);
		if (irq !== 1'b1) begin
			err_total++;
			end_of_test();
		end
	endtask : wait_irq

	initial begin
		{srst, ce, wr_stb, rd_stb, addr, wr_data} = {2'h3, 22'h0};
		status_in = '0;
		strap_in = '0;
		err_total = 0;
		checks_done = 0;
		w = 8'h00;
		n = $urandom(93036);
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		chk("cfg_out", {4'h0, cfg_out, irq}, 8'h00);
		wr(12'h288, 8'hFF);
		rd(12'h288, d);
		chk("board_identity", d, ID);
		rd(12'h2A5, d);
		chk("unmapped", d, 8'h00);
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_sys);
			status_in <= (i == 0) ? 6'h10 : 6'($urandom);
			strap_in <= 4'($urandom);
			w = (i == 1) ? 8'hFF : 8'($urandom);
			wr(12'h287, w);
			@(negedge clk_sys);
			chk("cfg_out", {5'h00, cfg_out}, {5'h00, w[6:5], w[0]});
			rd(12'h286, d);
			chk("io_status", d, {2'h0, status_in});
			rd(12'h287, d);
			chk("onboard_cfg", d, cfg_exp(w, strap_in));
		end
		// ce low must swallow the write
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(12'h287, ~w);
		@(posedge clk_sys);
		ce <= 1'b1;
		status_in <= '0;
		@(negedge clk_sys);
		chk("cfg_hold", {5'h00, cfg_out}, {5'h00, w[6:5], w[0]});
		wr(12'h291, 8'h07);
		rd(12'h290, d);
		rd(12'h291, d);
		chk("irq_mask", d, 8'h07);
		@(posedge clk_sys);
		status_in.supply_failure_flag <= 1'b1;
		wait_irq();
		chk("irq_set", {7'h00, irq}, 8'h01);
		rd(12'h290, d);
		chk("irq_status", d, 8'h02);
		repeat (2) @(negedge clk_sys);
		chk("irq_clear", {7'h00, irq}, 8'h00);
		wr(12'h291, 8'h00);
		@(posedge clk_sys);
		status_in.hot_insert_event_flag <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("irq_masked", {7'h00, irq}, 8'h00);
		rd(12'h290, d);
		chk("irq_status", d, 8'h04);
		// reset in mid-run clears stored config and the strap snapshot; straps are resampled before the readback
		wr(12'h287, 8'hFF);
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		chk("rst_cfg", {4'h0, cfg_out, irq}, 8'h00);
		rd(12'h287, d);
		chk("rst_cfg_rd", d, cfg_exp(8'h00, strap_in));
		end_of_test();
	end
endmodule : bio_regs_bench

// file: testbench/bio_regs_monitor.sv
/* port-level checks of the board register bank.
   bound onto every bio_regs; ce stays high around reads. */
`timescale 1ns/1ps
module bio_regs_monitor #(
	parameter logic [7:0] BOARD_IDENTITY_CODE = 8'h5C
) (
	input wire logic                    clk_sys,
	input wire logic                    srst,
	input wire logic                    ce,
	input wire logic [11:0]             addr,
	input wire logic [7:0]              wr_data,
	input wire logic                    wr_stb,
	input wire logic                    rd_stb,
	input wire logic [7:0]              rd_data,
	input wire bio_pkg::bio_status_in_t status_in,
	input wire bio_pkg::bio_strap_in_t  strap_in,
	input wire bio_pkg::bio_cfg_out_t   cfg_out,
	input wire logic                    irq
);
	// --------------------------------
	// properties
	// --------------------------------
	// --------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	rst_vals_a: assert property (
		$past(srst) |-> cfg_out == 3'h0 && !irq)
		else $error("state not cleared");
	rd_idle_a: assert property (!$past(rd_stb) && $past(ce)
		|-> rd_data == 8'h00) else $error("stray read data");
	id_read_a: assert property (
		$past(rd_stb && addr == 12'h288)
		|-> rd_data == BOARD_IDENTITY_CODE) else $error("bad identity");
	sts_read_a: assert property (
		$past(rd_stb && addr == 12'h286)
		|-> rd_data == {2'h0, $past(status_in, 2)})
		else $error("bad status");
	cfg_strap_a: assert property (
		$past(rd_stb && addr == 12'h287)
		|-> {rd_data[7], rd_data[4:1]} == {1'h0, $past(strap_in, 2)})
		else $error("bad straps");
	cfg_read_a: assert property (
		$past(rd_stb && addr == 12'h287)
		|-> {rd_data[6:5], rd_data[0]} == $past(cfg_out))
		else $error("bad config readback");
	cfg_write_a: assert property (
		$past(wr_stb && ce && addr == 12'h287)
		|-> cfg_out == {$past(wr_data[6]), $past(wr_data[5]),
		$past(wr_data[0])}) else $error("config not stored");
	// a reset edge may legally clear the config, so it is left out
	cfg_hold_a: assert property (
		!$past(srst) && !$past(wr_stb && addr == 12'h287)
		|-> $stable(cfg_out)) else $error("config changed");
endmodule : bio_regs_monitor

bind bio_regs bio_regs_monitor #(.BOARD_IDENTITY_CODE(BOARD_IDENTITY_CODE)) mon (
	.clk_sys(clk_sys), .srst(srst), .ce(ce), .addr(addr),
	.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rd_data(rd_data), .status_in(status_in), .strap_in(strap_in),
	.cfg_out(cfg_out), .irq(irq));
